// ==== testbench/llw_host_model.sv ====
// Host model issuing register commands to the configuration bank
`timescale 1ns/1ns
module llw_host_model (
  // Clock
  input wire logic CLK,
  // Register command port
  output logic [7:0] REG_ADDR,
  output logic REG_WR,
  output logic REG_RD,
  output logic [15:0] REG_WDATA,
  input wire logic [15:0] REG_RDATA
);
  initial begin
    REG_ADDR = 8'hFF;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_WDATA = 16'h0000;
  end

  // Idle code and data are inverted so a stale value never looks like a live request
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
    REG_ADDR <= ~a;
    REG_WDATA <= ~d;
  endtask : wr

  // Read data is taken one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    REG_ADDR <= ~a;
    @(posedge CLK);
    @(negedge CLK);
    d = REG_RDATA;
  endtask : rd

  // Write then read the same code on the next edge
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    REG_ADDR <= ~a;
    REG_WDATA <= ~d;
    @(posedge CLK);
    @(negedge CLK);
    q = REG_RDATA;
  endtask : wr_rd
endmodule : llw_host_model

// ==== testbench/test_llc_loop_weight_and_telemetry_cfg.sv ====
// Self-checking bench for the loop weight and telemetry configuration bank
`timescale 1ns/1ns
module test_llc_loop_weight_and_telemetry_cfg
  import llw_pkg::*;
;
  logic clk;
  logic rstn;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic gate;
  logic set_p;
  logic hi_f;
  logic lo_f;
  logic [5:0] blank;
  logic [9:0] tmin;
  logic [9:0] tmax;
  logic pdone;
  logic [15:0] sdly;
  llw_samples_t smp;
  logic [9:0] ton_out;
  logic ton_adj;
  logic rect_en;
  logic pwm_en;
  logic uvlo;
  logic ov;
  logic [9:0] rvin;
  logic [8:0] rvout;
  logic [9:0] riout;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;

  llw_host_model host (.CLK(clk), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata));

  llw_loop_cfg uut (.CLK(clk), .RSTN(rstn), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .PRIMARY_GATE_PULSE(gate), .SET_PULSE(set_p),
    .HIGH_SIDE_SPIKE_FLAG(hi_f), .LOW_SIDE_SPIKE_FLAG(lo_f), .LOOP_BLANKING_INTERVAL(blank),
    .TON_MIN_LIMIT(tmin), .TON_MAX_LIMIT(tmax), .PROTECT_DELAY_DONE(pdone), .START_DELAY_CYCLES(sdly),
    .SAMPLES(smp), .TON_OUT(ton_out), .TON_ADJUST(ton_adj), .RECTIFIER_GATE_ENABLE(rect_en),
    .PWM_ENABLE(pwm_en), .VIN_UVLO(uvlo), .VIN_OV_FAULT(ov), .READ_VIN(rvin), .READ_VOUT(rvout),
    .READ_IOUT(riout));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_of_test;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // A hang counts as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      $display("CHECK FAILED run length expected finish seen hang");
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic t_regs;
    logic [15:0] d;
    for (int i = 0; i < NUM_REGS; i++) begin
      host.rd(REG_ADDR_MAP[i], d);
      chk("reset value", REG_RESET[i], d);
      host.wr(REG_ADDR_MAP[i], 16'hFFFF);
      host.rd(REG_ADDR_MAP[i], d);
      chk("writable bits", REG_WMASK[i], d);
    end
    host.wr(8'h37, 16'hFFFF);
    host.rd(8'h37, d);
    chk("unmapped read", 16'h0000, d);
    host.wr_rd(8'h40, 16'hFFFF, d);
    chk("write then read", REG_WMASK[IDX_OVLIM], d);
    $display("test registers done");
  endtask : t_regs

  task automatic t_tel;
    logic [15:0] d;
    @(posedge clk);
    smp <= '{vin: 10'h190, vout: 10'h064, iout: 10'h0C8};
    host.wr(8'h3A, 16'h00CD);
    host.wr(8'h3B, 16'h0029);
    host.wr(8'h38, 16'h0029);
    host.wr(8'h39, 16'h003D);
    host.wr(8'h40, 16'h0096);
    settle(4);
    chk("read vin", 16'(400 * 205 / 205), 16'(rvin));
    chk("read vout", 16'(100 * 205 / (4 * 41)), 16'(rvout));
    chk("read iout", 16'(200 * 205 / (2 * 41) - 3), 16'(riout));
    host.rd(ADDR_READ_IOUT, d);
    chk("read iout code", 16'(200 * 205 / (2 * 41) - 3), d);
    chk("ov fault", 16'h0001, 16'(ov));
    host.wr(8'h40, 16'h012C);
    settle(4);
    chk("ov clear", 16'h0000, 16'(ov));
    $display("test telemetry done");
  endtask : t_tel

  task automatic t_pwr;
    int first;
    first = 0;
    host.wr(8'h36, 16'h0050);
    host.wr(8'h35, 16'h01FF);
    settle(4);
    chk("uvlo while off", 16'h0001, 16'(uvlo));
    host.wr(8'h35, 16'h0064);
    settle(6);
    chk("uvlo clear", 16'h0000, 16'(uvlo));
    chk("pwm before protect", 16'h0000, 16'(pwm_en));
    @(posedge clk);
    pdone <= 1'b1;
    for (int i = 1; i <= 12; i++) begin
      @(posedge clk);
      @(negedge clk);
      if (first == 0 && pwm_en === 1'b1) begin
        first = i;
      end
    end
    chk("start delay", 16'(5 + 2), 16'(first));
    host.wr(8'h35, 16'h01FF);
    host.wr(8'h36, 16'h01F0);
    settle(4);
    chk("uvlo while on", 16'h0001, 16'(uvlo));
    chk("pwm stopped", 16'h0000, 16'(pwm_en));
    @(posedge clk);
    pdone <= 1'b0;
    $display("test power sequence done");
  endtask : t_pwr

  task automatic t_rect;
    logic [9:0] vin_tab [5] = '{10'h1FE, 10'h1F1, 10'h1EA, 10'h1F6, 10'h1FE};
    logic en_tab [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    host.wr(8'h34, 16'h0043);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      smp <= '{vin: vin_tab[i], vout: 10'h1F4, iout: 10'h0C8};
      settle(3);
      chk("rectifier enable", 16'(en_tab[i]), 16'(rect_en));
    end
    $display("test rectifier done");
  endtask : t_rect

  // One 60-cycle period, 40 high; checks the adjustment made for the period before it
  task automatic period(input int off, input bit spk, input int dlt, input int absv);
    logic [9:0] t0;
    logic [9:0] got;
    logic seen;
    t0 = ton_out;
    seen = 1'b0;
    got = 10'h000;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      gate <= (i < 40);
      set_p <= (off > 0) && (i == off || i == off + 1);
      lo_f <= spk && (i >= 5) && (i <= 8);
      @(negedge clk);
      if (i < 8 && ton_adj === 1'b1) begin
        seen = 1'b1;
        got = ton_out;
      end
    end
    if (absv > -2) begin
      chk("on-time step seen", 16'h0001, 16'(seen));
      chk("on-time", 16'((absv < 0) ? 10'(int'(t0) + dlt) : 10'(absv)), 16'(got));
    end
  endtask : period

  task automatic t_loop;
    host.wr(8'h30, 16'h9088);
    host.wr(8'h31, 16'h2018);
    host.wr(8'h32, 16'h1002);
    host.wr(8'h33, 16'h0914);
    period(0, 0, 0, -2);
    period(5, 0, 0, 10);
    period(15, 0, 32, -1);
    period(25, 0, 24, -1);
    period(33, 0, 16, -1);
    period(0, 0, 8, -1);
    period(0, 1, -2, -1);
    period(0, 0, -18, -1);
    @(posedge clk);
    blank <= 6'h10;
    period(12, 0, 18, -1);
    period(3, 0, 32, -1);
    period(5, 0, -2, -1);
    @(posedge clk);
    hi_f <= 1'b1;
    repeat (4) @(posedge clk);
    hi_f <= 1'b0;
    period(0, 0, 7, -1);
    @(posedge clk);
    tmax <= 10'h064;
    period(0, 0, 0, 100);
    $display("test loop weights done");
  endtask : t_loop

  initial begin
    rstn = 1'b0;
    gate = 1'b0;
    set_p = 1'b0;
    hi_f = 1'b0;
    lo_f = 1'b0;
    blank = 6'h00;
    tmin = 10'h00A;
    tmax = 10'h3E8;
    pdone = 1'b0;
    sdly = 16'h0005;
    smp = '0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_tel();
    t_pwr();
    t_rect();
    t_loop();
    end_of_test();
  end
endmodule : test_llc_loop_weight_and_telemetry_cfg

// ==== verilog/llw_loop_cfg.sv ====
// Loop weight, input drop, UVLO/OVP and telemetry configuration bank
`timescale 1ns/1ns
// Functional notes
// - Set in third quarter: raise on-time by late register bits 14:8.
// - Set in final quarter, not last 5ns: raise by late bits 6:0.
// - Set in first quarter: raise on-time by early register bits 14:8.
// - Set in second quarter: raise on-time by early register bits 6:0.
// - Quarters split only the pulse part after the blanking interval.
// - No set during a pulse period: lower on-time by decrement bits 7:0.
// - Low-side spike flag: lower on-time by decrement bits 15:8.
// - After high-side spike flag falls, recover on-time by bits 14:8 steps.
// - After low-side spike flag falls, recover on-time by bits 6:0 steps.
// - Stop rectifier gates when input sample below output minus drop delta.
// - Resume rectifier gates when input sample above output plus restart threshold.
// - After turn-on level: protection delay, then start delay, then PWM.
// - UVLO when input at/below turn-on while off, or below turn-off.
// - Current reading is sample*205/(2*gain) plus signed 6-bit offset.
// - Input reading is sample*205 divided by input gain.
// - Output reading bits 8:0 is sample*205/(4*gain).
// - Input over-voltage fault compares limit with input reading bits 9:1.
// - Over-voltage limit is nine bits at half the input reading's scale.
// - Writable reserved bits store only; undefined reserved bits read zero.
module llw_loop_cfg
  import llw_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // Register command port
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  // Asynchronous loop pins
  input wire logic PRIMARY_GATE_PULSE,
  input wire logic SET_PULSE,
  input wire logic HIGH_SIDE_SPIKE_FLAG,
  input wire logic LOW_SIDE_SPIKE_FLAG,
  // Loop configuration from neighbouring registers
  input wire logic [5:0] LOOP_BLANKING_INTERVAL,
  input wire logic [9:0] TON_MIN_LIMIT,
  input wire logic [9:0] TON_MAX_LIMIT,
  // Start-up sequencing
  input wire logic PROTECT_DELAY_DONE,
  input wire logic [15:0] START_DELAY_CYCLES,
  // ADC samples, same clock
  input wire llw_samples_t SAMPLES,
  // Results
  output logic [9:0] TON_OUT,
  output logic TON_ADJUST,
  output logic RECTIFIER_GATE_ENABLE,
  output logic PWM_ENABLE,
  output logic VIN_UVLO,
  output logic VIN_OV_FAULT,
  output logic [9:0] READ_VIN,
  output logic [8:0] READ_VOUT,
  output logic [9:0] READ_IOUT
);

  llw_state_t q;
  llw_state_t d;

  logic gate_rise;
  logic gate_fall;
  logic set_edge;
  logic hi_rise;
  logic hi_fall;
  logic lo_rise;
  logic lo_fall;
  logic [11:0] blank_c;
  logic [11:0] rem;
  logic [11:0] pos;
  logic [13:0] pos4;
  logic [13:0] rem1;
  logic [13:0] rem2;
  logic [13:0] rem3;
  logic in_blank;
  logic [6:0] qw;
  logic spk;
  logic signed [12:0] sum;
  logic [9:0] ton_new;
  logic [17:0] num_vin;
  logic [17:0] num_vout;
  logic [17:0] num_iout;
  logic [17:0] quo_vin;
  logic [17:0] quo_vout;
  logic [17:0] quo_iout;
  logic signed [19:0] iout_s;
  logic [9:0] vi_gain;
  logic [9:0] vo_gain;
  logic [9:0] i_gain;
  logic [10:0] vin_lo;
  logic [10:0] vout_lo;
  logic [8:0] vin9;
  logic [15:0] rd_mux;

  always_comb begin
    d = q;
    // Two-stage pin synchronisers; stage 2 holds the previous value for edges
    d.gate_s = {q.gate_s[1:0], PRIMARY_GATE_PULSE};
    d.set_s = {q.set_s[1:0], SET_PULSE};
    d.hi_s = {q.hi_s[1:0], HIGH_SIDE_SPIKE_FLAG};
    d.lo_s = {q.lo_s[1:0], LOW_SIDE_SPIKE_FLAG};
    gate_rise = q.gate_s[1] & ~q.gate_s[2];
    gate_fall = ~q.gate_s[1] & q.gate_s[2];
    set_edge = q.set_s[1] & ~q.set_s[2];
    hi_rise = q.hi_s[1] & ~q.hi_s[2];
    hi_fall = ~q.hi_s[1] & q.hi_s[2];
    lo_rise = q.lo_s[1] & ~q.lo_s[2];
    lo_fall = ~q.lo_s[1] & q.lo_s[2];

    // Remaining pulse after blanking, using the last pulse length as the estimate
    blank_c = 12'((int'(LOOP_BLANKING_INTERVAL) * BLK_NS_PER_LSB + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    rem = (q.plen > blank_c) ? q.plen - blank_c : 12'h000;
    in_blank = (q.pcnt < blank_c);
    pos = in_blank ? 12'h000 : q.pcnt - blank_c;
    pos4 = {pos, 2'b00};
    rem1 = {2'b00, rem};
    rem2 = {1'b0, rem, 1'b0};
    rem3 = rem1 + rem2;
    if ((rem == 12'h000) || ({2'b00, pos} + 14'(LAST_EXCL_CYC) >= rem1)) begin
      qw = 7'h00;
    end else if (pos4 >= rem3) begin
      qw = q.regs[IDX_LATE_W][LO_LSB +: W7];
    end else if (pos4 >= rem2) begin
      qw = q.regs[IDX_LATE_W][HI_LSB +: W7];
    end else if (pos4 >= rem1) begin
      qw = q.regs[IDX_EARLY_W][LO_LSB +: W7];
    end else begin
      qw = q.regs[IDX_EARLY_W][HI_LSB +: W7];
    end

    // Pulse length and first accepted set of the pulse
    if (gate_rise) begin
      d.pcnt = 12'h000;
    end else if (q.gate_s[1] && q.pcnt != 12'hFFF) begin
      d.pcnt = q.pcnt + 12'h001;
    end
    if (gate_fall) begin
      d.plen = q.pcnt;
    end
    if (set_edge && q.gate_s[1] && !in_blank && !q.set_seen && !gate_rise) begin
      d.set_seen = 1'b1;
      d.set_w = qw;
    end

    // Spike bookkeeping; a new spike wins over a clear in the same cycle
    if (hi_rise) begin
      d.rec_h = 1'b0;
      d.tgt_h = q.ton;
    end else if (hi_fall) begin
      d.rec_h = 1'b1;
    end
    if (lo_rise) begin
      d.rec_l = 1'b0;
      d.tgt_l = q.ton;
    end else if (lo_fall) begin
      d.rec_l = 1'b1;
    end
    spk = q.lo_hit | lo_rise;
    d.lo_hit = spk;

    // One net adjustment at each period boundary, then clamp
    sum = 13'(q.ton);
    if (q.set_seen) begin
      sum = sum + 13'(q.set_w);
    end else begin
      sum = sum - 13'(q.regs[IDX_DECR_W][LO_LSB +: W8]);
    end
    if (spk) begin
      sum = sum - 13'(q.regs[IDX_DECR_W][HI_LSB +: W8]);
    end else begin
      if (q.rec_h && !hi_rise) begin
        sum = sum + 13'(q.regs[IDX_RECOV_W][HI_LSB +: W7]);
      end
      if (q.rec_l && !lo_rise) begin
        sum = sum + 13'(q.regs[IDX_RECOV_W][LO_LSB +: W7]);
      end
    end
    // Signed compare, so that a large decrement clamps to the minimum and never wraps to the maximum
    if (sum < $signed(13'(TON_MIN_LIMIT))) begin
      ton_new = TON_MIN_LIMIT;
    end else if (sum > $signed(13'(TON_MAX_LIMIT))) begin
      ton_new = TON_MAX_LIMIT;
    end else begin
      ton_new = sum[9:0];
    end
    d.adj = gate_rise;
    if (gate_rise) begin
      d.ton = ton_new;
      d.set_seen = 1'b0;
      d.lo_hit = lo_rise;
      if (q.rec_h && !hi_rise && ton_new >= q.tgt_h) begin
        d.rec_h = 1'b0;
      end
      if (q.rec_l && !lo_rise && ton_new >= q.tgt_l) begin
        d.rec_l = 1'b0;
      end
    end

    // Input drop hysteresis on raw samples
    vin_lo = {1'b0, SAMPLES.vin};
    vout_lo = {1'b0, SAMPLES.vout};
    if (vin_lo + 11'(q.regs[IDX_DROP][DELTA_LSB +: NIB_W]) < vout_lo) begin
      d.rect_en = 1'b0;
    end else if (vin_lo > vout_lo + 11'(q.regs[IDX_DROP][LO_LSB +: NIB_W])) begin
      d.rect_en = 1'b1;
    end

    // Telemetry scaling; a zero gain saturates the reading
    vi_gain = q.regs[IDX_VIGAIN][LO_LSB +: GAIN_W];
    vo_gain = q.regs[IDX_VOGAIN][LO_LSB +: GAIN_W];
    i_gain = q.regs[IDX_IGAIN][LO_LSB +: GAIN_W];
    num_vin = 18'(SAMPLES.vin * TEL_MULT);
    num_vout = 18'(SAMPLES.vout * TEL_MULT);
    num_iout = 18'(SAMPLES.iout * TEL_MULT);
    quo_vin = (vi_gain == 10'h000) ? 18'h3FFFF : num_vin / 18'(vi_gain);
    quo_vout = (vo_gain == 10'h000) ? 18'h3FFFF : num_vout / 18'({vo_gain, 2'b00});
    quo_iout = (i_gain == 10'h000) ? 18'h3FFFF : num_iout / 18'({i_gain, 1'b0});
    d.read_vin = (quo_vin > 18'(TEL_MAX10)) ? TEL_MAX10 : quo_vin[9:0];
    d.read_vout = (quo_vout > 18'(TEL_MAX9)) ? TEL_MAX9 : quo_vout[8:0];
    iout_s = $signed({2'b00, quo_iout}) + 20'($signed(q.regs[IDX_IOFFS][LO_LSB +: OFFS_W]));
    if (iout_s < 20'sd0) begin
      d.read_iout = 10'h000;
    end else if (iout_s > $signed(20'(TEL_MAX10))) begin
      d.read_iout = TEL_MAX10;
    end else begin
      d.read_iout = iout_s[9:0];
    end

    // Limits compare against the 0.25V bits of the input reading
    vin9 = q.read_vin[9:1];
    d.ov = vin9 > q.regs[IDX_OVLIM][LO_LSB +: LVL_W];
    d.uvlo = ((vin9 <= q.regs[IDX_VON][LO_LSB +: LVL_W]) && (q.pwr == PWR_OFF)) ||
             (vin9 < q.regs[IDX_VOFF][LO_LSB +: LVL_W]);

    // Start-up sequence; UVLO drops back to off from any state
    case (q.pwr)
      PWR_OFF: begin
        if (!q.uvlo && !d.uvlo) begin
          d.pwr = PWR_PROTECT;
        end
      end
      PWR_PROTECT: begin
        if (PROTECT_DELAY_DONE) begin
          d.pwr = PWR_START;
          d.sdcnt = START_DELAY_CYCLES;
        end
      end
      PWR_START: begin
        if (q.sdcnt == 16'h0000) begin
          d.pwr = PWR_RUN;
        end else begin
          d.sdcnt = q.sdcnt - 16'h0001;
        end
      end
      PWR_RUN: begin
        d.pwr = PWR_RUN;
      end
      default: begin
        d.pwr = PWR_OFF;
      end
    endcase
    if (q.uvlo) begin
      d.pwr = PWR_OFF;
    end
    d.pwm_en = (d.pwr == PWR_RUN);

    // Register writes keep only defined bits; undefined bits stay zero
    for (int i = 0; i < NUM_REGS; i++) begin
      if (REG_WR && REG_ADDR == REG_ADDR_MAP[i]) begin
        d.regs[i] = REG_WDATA & REG_WMASK[i];
      end
    end
    rd_mux = 16'h0000;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (REG_ADDR == REG_ADDR_MAP[i]) begin
        rd_mux = q.regs[i];
      end
    end
    if (REG_ADDR == ADDR_READ_VIN) begin
      rd_mux = {6'h00, q.read_vin};
    end else if (REG_ADDR == ADDR_READ_VOUT) begin
      rd_mux = {7'h00, q.read_vout};
    end else if (REG_ADDR == ADDR_READ_IOUT) begin
      rd_mux = {6'h00, q.read_iout};
    end
    if (REG_RD) begin
      d.rdata = rd_mux;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      q <= '0;
      q.regs <= REG_RESET;
      q.pwr <= PWR_OFF;
    end else begin
      q <= d;
    end
  end

  assign REG_RDATA = q.rdata;
  assign TON_OUT = q.ton;
  assign TON_ADJUST = q.adj;
  assign RECTIFIER_GATE_ENABLE = q.rect_en;
  assign PWM_ENABLE = q.pwm_en;
  assign VIN_UVLO = q.uvlo;
  assign VIN_OV_FAULT = q.ov;
  assign READ_VIN = q.read_vin;
  assign READ_VOUT = q.read_vout;
  assign READ_IOUT = q.read_iout;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence s_write_ovlim;
    REG_WR && REG_ADDR == 8'h40;
  endsequence
  sequence s_read_ovlim;
    REG_RD && REG_ADDR == 8'h40 && !REG_WR;
  endsequence

  AST_READBACK: assert property (s_write_ovlim ##1 s_read_ovlim |=>
    REG_RDATA == ($past(REG_WDATA, 2) & 16'h01FF))
    else $error("written limit not read back masked");
  AST_UNDEF_ZERO: assert property (REG_RD && REG_ADDR == 8'h35 |=> REG_RDATA[15:9] == 7'h00)
    else $error("undefined bits of turn-on level read non-zero");
  AST_ONE_ADJ: assert property (TON_ADJUST |=> !TON_ADJUST)
    else $error("two adjustments in consecutive cycles");
  AST_CLAMP: assert property (TON_ADJUST && $past(TON_MIN_LIMIT) <= $past(TON_MAX_LIMIT) |->
    TON_OUT >= $past(TON_MIN_LIMIT) && TON_OUT <= $past(TON_MAX_LIMIT))
    else $error("on-time outside limits");
  AST_RECT_STOP: assert property ({1'b0, SAMPLES.vin} + 11'(q.regs[IDX_DROP][7:4]) < {1'b0, SAMPLES.vout}
    |=> !RECTIFIER_GATE_ENABLE)
    else $error("rectifier not stopped on input drop");
  AST_RECT_RUN: assert property (!RECTIFIER_GATE_ENABLE &&
    {1'b0, SAMPLES.vin} > {1'b0, SAMPLES.vout} + 11'(q.regs[IDX_DROP][3:0]) &&
    {1'b0, SAMPLES.vin} + 11'(q.regs[IDX_DROP][7:4]) >= {1'b0, SAMPLES.vout} |=> RECTIFIER_GATE_ENABLE)
    else $error("rectifier not resumed");
  AST_UVLO_OFF: assert property (q.pwr == PWR_OFF && READ_VIN[9:1] <= q.regs[IDX_VON][8:0] |=> VIN_UVLO)
    else $error("no lockout at turn-on level while off");
  AST_PWM_SEQ: assert property ($rose(PWM_ENABLE) |-> $past(q.pwr) == PWR_START && $past(q.sdcnt) == 16'h0000)
    else $error("PWM enabled without start delay");
  AST_OV: assert property (READ_VIN[9:1] > q.regs[IDX_OVLIM][8:0] |=> VIN_OV_FAULT)
    else $error("over-voltage not flagged");
  AST_BLANK: assert property (set_edge && in_blank && !q.set_seen |=> !q.set_seen)
    else $error("set accepted inside blanking");
  AST_NOSET_DEC: assert property (gate_rise && !q.set_seen && !spk && !q.rec_h && !q.rec_l &&
    int'(q.ton) - int'(q.regs[IDX_DECR_W][7:0]) >= int'(TON_MIN_LIMIT) && q.ton <= TON_MAX_LIMIT |=>
    TON_OUT == $past(q.ton) - 10'($past(q.regs[IDX_DECR_W][7:0])))
    else $error("no-set decrement wrong");

  // Register bus checks
  AST_OFFS_UNDEF: assert property (REG_RD && REG_ADDR == 8'h39 |=> REG_RDATA[15:6] == 10'h000)
    else $error("undefined bits of current offset read non-zero");
  AST_RDATA_HOLD: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data changed without a read");

  // Power and limit checks
  AST_PWM_UVLO: assert property (VIN_UVLO |=> !PWM_ENABLE)
    else $error("PWM still enabled under lockout");
  AST_UVLO_LOW: assert property (READ_VIN[9:1] < q.regs[IDX_VOFF][8:0] |=> VIN_UVLO)
    else $error("no lockout below turn-off level");
  AST_OV_CLEAR: assert property (READ_VIN[9:1] <= q.regs[IDX_OVLIM][8:0] |=> !VIN_OV_FAULT)
    else $error("over-voltage flagged at or below limit");

endmodule : llw_loop_cfg

// ==== verilog/llw_pkg.sv ====
// Constants and carrier types for the loop weight and telemetry configuration bank
package llw_pkg;

  // Register map, index 0 to 11
  localparam int unsigned NUM_REGS = 12;
  localparam int unsigned REG_W = 16;
  localparam int unsigned IDX_LATE_W = 0;
  localparam int unsigned IDX_EARLY_W = 1;
  localparam int unsigned IDX_DECR_W = 2;
  localparam int unsigned IDX_RECOV_W = 3;
  localparam int unsigned IDX_DROP = 4;
  localparam int unsigned IDX_VON = 5;
  localparam int unsigned IDX_VOFF = 6;
  localparam int unsigned IDX_IGAIN = 7;
  localparam int unsigned IDX_IOFFS = 8;
  localparam int unsigned IDX_VIGAIN = 9;
  localparam int unsigned IDX_VOGAIN = 10;
  localparam int unsigned IDX_OVLIM = 11;
  localparam logic [NUM_REGS-1:0][7:0] REG_ADDR_MAP = {
    8'h40, 8'h3B, 8'h3A, 8'h39, 8'h38, 8'h36, 8'h35, 8'h34, 8'h33, 8'h32, 8'h31, 8'h30};
  // Bits that store a write; the rest read as zero
  localparam logic [NUM_REGS-1:0][15:0] REG_WMASK = {
    16'h01FF, 16'h03FF, 16'h03FF, 16'h003F, 16'h03FF, 16'h01FF, 16'h01FF, 16'h1FFF,
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
  localparam logic [NUM_REGS-1:0][15:0] REG_RESET = '0;

  // Read-only telemetry results
  localparam logic [7:0] ADDR_READ_VIN = 8'h88;
  localparam logic [7:0] ADDR_READ_VOUT = 8'h8B;
  localparam logic [7:0] ADDR_READ_IOUT = 8'h8C;

  // Field positions
  localparam int unsigned HI_LSB = 8;
  localparam int unsigned LO_LSB = 0;
  localparam int unsigned W7 = 7;
  localparam int unsigned W8 = 8;
  localparam int unsigned DELTA_LSB = 4;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned LVL_W = 9;
  localparam int unsigned GAIN_W = 10;
  localparam int unsigned OFFS_W = 6;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned BLK_NS_PER_LSB = 5;
  localparam int unsigned LAST_EXCL_NS = 5;
  localparam int unsigned LAST_EXCL_CYC =
    (LAST_EXCL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
    (LAST_EXCL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Telemetry scaling
  localparam logic [7:0] TEL_MULT = 8'hCD;
  localparam logic [9:0] TEL_MAX10 = 10'h3FF;
  localparam logic [8:0] TEL_MAX9 = 9'h1FF;

  typedef enum logic [1:0] {PWR_OFF, PWR_PROTECT, PWR_START, PWR_RUN} llw_pwr_t;

  typedef struct packed {
    logic [9:0] vin;
    logic [9:0] vout;
    logic [9:0] iout;
  } llw_samples_t;

  typedef struct packed {
    logic [NUM_REGS-1:0][15:0] regs;
    logic [15:0] rdata;
    logic [2:0] gate_s;
    logic [2:0] set_s;
    logic [2:0] hi_s;
    logic [2:0] lo_s;
    logic [11:0] pcnt;
    logic [11:0] plen;
    logic set_seen;
    logic [6:0] set_w;
    logic lo_hit;
    logic rec_h;
    logic rec_l;
    logic [9:0] tgt_h;
    logic [9:0] tgt_l;
    logic [9:0] ton;
    logic adj;
    logic rect_en;
    llw_pwr_t pwr;
    logic [15:0] sdcnt;
    logic pwm_en;
    logic [9:0] read_vin;
    logic [8:0] read_vout;
    logic [9:0] read_iout;
    logic uvlo;
    logic ov;
  } llw_state_t;

endpackage : llw_pkg
